// file: src/vrc_map.vh
// constants for the video dram random port cycle controller
`ifndef VRC_MAP_VH
`define VRC_MAP_VH
// wishbone register offsets (byte addresses)
`define VRC_REG_CMD      4'h0
`define VRC_REG_ADDR     4'h4
`define VRC_REG_DATA     4'h8
`define VRC_REG_STATUS   4'hc
// command field positions in the command register
`define VRC_CMD_OP_LSB   0
`define VRC_CMD_OP_MSB   3
`define VRC_CMD_REF_EN   4
`define VRC_CMD_PIN_MSB  7
// operation codes
`define VRC_OP_READ      4'h0
`define VRC_OP_WRITE     4'h1
`define VRC_OP_LATE_WR   4'h2
`define VRC_OP_MASK_WR   4'h3
`define VRC_OP_BLOCK_WR  4'h4
`define VRC_OP_LOAD_MASK 4'h5
`define VRC_OP_LOAD_COL  4'h6
`define VRC_OP_REF_ROW   4'h7
`define VRC_OP_REF_KEEP  4'h8
`define VRC_OP_REF_STOP  4'h9
`define VRC_OP_REF_ALL   4'ha
`define VRC_OP_HIDDEN    4'hb
// status bit positions
`define VRC_ST_BUSY      0
`define VRC_ST_PERSIST   1
`define VRC_ST_COLOR_OK  2
`define VRC_ST_BAD_OP    3
// refresh: 512 rows every 16.7 ms, at 40 mhz (25 ns)
`define VRC_REF_ROWS     512
`define VRC_REF_WIN_US   16700
`define VRC_CLK_MHZ      40
`define VRC_REF_INTERVAL ((`VRC_REF_WIN_US * `VRC_CLK_MHZ) / `VRC_REF_ROWS)
// strobe phase length in clocks
`define VRC_PHASE_CLKS   3
// reset values
`define VRC_RST_CMD      8'h00
`define VRC_RST_ADDR     18'h00000
`define VRC_RST_DATA     8'h00
`endif

// file: src/vrc_ctrl.v
// controller driving the random port of a 256k x 8 video dram
// How it works
// RULE1: refresh 512 rows every 16.7 ms
// RULE2: device counts rows in column-before-row refresh
// RULE3: three column-before-row refresh variants exist
// RULE4: row address given at row strobe fall
// RULE5: data pins undriven during refresh cycles
// RULE6: hidden refresh toggles row strobe, column low
// RULE7: every access also refreshes its row
// RULE8: nine row, nine column bits latched
// RULE9: nothing starts while row strobe high
// RULE10: transfer pin high at row fall for access
// RULE11: read needs write enable high, output enable
// RULE12: mask and special low select masked write
// RULE13: early or late write by enable timing
// RULE14: nonpersistent masked write after power-up
// RULE15: mask zero blocks bit, one writes
// RULE16: mask load makes masked writes persistent
// RULE17: refresh with special low clears persistence
// RULE18: keep-options refresh leaves persistence alone
// RULE19: same mask for whole page cycle
// RULE20: special high at column fall means block
// RULE21: block uses column bits two to eight
// RULE22: load colour before any block write
// RULE23: register load cycle, special low loads mask
// RULE24: colour load like mask, special high
// RULE25: column enable one writes, zero suppresses
// RULE26: pin one enables column 00 etc
`timescale 1ns/1ps
`include "vrc_map.vh"

module vrc_ctrl #(
    parameter REF_INTERVAL = `VRC_REF_INTERVAL  // clocks between refreshes
) (
    // clock and reset
    input  wire        sys_clk_i,
    input  wire        rst_b_i,
    // classic wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output wire        wb_ack_o,
    // video dram control pins
    output reg         row_strobe_n_o,
    output reg         column_strobe_n_o,
    output reg         transfer_or_output_enable_n_o,
    output reg         mask_or_write_enable_n_o,
    output reg         special_function_select_o,
    output reg         special_function_select_one_o,
    output reg  [8:0]  multiplexed_address_pins_o,
    // parallel data pins, split three ways
    input  wire [7:0]  parallel_data_pins_i,
    output reg  [7:0]  parallel_data_pins_o,
    output reg         parallel_data_pins_oe_o
);

    // states of the cycle sequencer
    localparam ST_IDLE   = 3'd0;  // row strobe high, pins parked
    localparam ST_ROW    = 3'd1;  // row strobe falls
    localparam ST_COL    = 3'd2;  // column strobe falls
    localparam ST_LATE   = 3'd3;  // late write enable fall
    localparam ST_HOLD   = 3'd4;  // strobes held low (column stays high in row-only refresh), read sample
    localparam ST_PRE    = 3'd5;  // precharge, all strobes high
    localparam ST_HID    = 3'd6;  // hidden refresh row toggle

    // registers seen by software
    reg  [7:0]  cmd;            // last command, refresh enable bit
    reg  [17:0] addr;           // row in 17:9, column in 8:0
    reg  [7:0]  wdata;          // write data, mask or column enables
    reg  [7:0]  rdata;          // data captured on a read
    reg         busy;           // cycle in progress
    reg         persist;        // mirror of device masked-write mode
    reg         color_ok;       // colour register loaded since reset
    reg         bad_op;         // refused command, sticky

    // sequencer state
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [3:0]  op;             // operation being run
    reg  [1:0]  phase;          // clocks spent in current state
    reg         auto_ref;       // cycle started by refresh timer
    reg  [23:0] ref_cnt;        // refresh interval timer
    reg         ref_due;        // refresh owed

    // two-flop synchroniser for the returning data pins
    reg  [7:0]  dq_meta;
    reg  [7:0]  dq_sync;

    // wishbone decode; ack is combinational
    wire        wb_hit   = wb_cyc_i & wb_stb_i;
    wire        wr_cmd   = wb_hit & wb_we_i & wb_sel_i[0]
                           & (wb_adr_i == `VRC_REG_CMD);
    wire [3:0]  new_op   = wb_dat_i[`VRC_CMD_OP_MSB:`VRC_CMD_OP_LSB];
    wire        op_valid = (new_op <= `VRC_OP_HIDDEN);
    // no block write before a colour load
    wire        op_ok    = op_valid & ~(new_op == `VRC_OP_BLOCK_WR
                                        & ~color_ok);  // see RULE22
    wire        start    = wr_cmd & ~busy & op_ok;
    wire        phase_done = (phase == `VRC_PHASE_CLKS - 1);

    // classification of the running operation
    wire is_cbr   = (op == `VRC_OP_REF_KEEP) | (op == `VRC_OP_REF_STOP)
                  | (op == `VRC_OP_REF_ALL) | (op == `VRC_OP_HIDDEN);
    wire is_write = (op == `VRC_OP_WRITE) | (op == `VRC_OP_LATE_WR)
                  | (op == `VRC_OP_MASK_WR) | (op == `VRC_OP_BLOCK_WR);
    wire is_load  = (op == `VRC_OP_LOAD_MASK) | (op == `VRC_OP_LOAD_COL);

    assign wb_ack_o = wb_hit;

    // read mux; unmapped offsets read zero
    always @*
    begin
        case (wb_adr_i)
            `VRC_REG_CMD:    wb_dat_o = {24'h000000, cmd};
            `VRC_REG_ADDR:   wb_dat_o = {14'h0000, addr};
            `VRC_REG_DATA:   wb_dat_o = {16'h0000, rdata, wdata};
            `VRC_REG_STATUS: wb_dat_o = {28'h0000000, bad_op, color_ok,
                                         persist, busy};
            default:         wb_dat_o = 32'h00000000;
        endcase
    end

    // data pin synchroniser
    always @(posedge sys_clk_i)
    begin
        dq_meta <= parallel_data_pins_i;
        dq_sync <= dq_meta;
    end

    // refresh timer, one row per interval
    always @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            ref_cnt <= 24'h000000;
            ref_due <= 1'b0;
        end
        else
        begin
            if (ref_cnt >= REF_INTERVAL[23:0] - 24'h000001)
            begin
                ref_cnt <= 24'h000000;
                ref_due <= cmd[`VRC_CMD_REF_EN];  // see RULE1
            end
            else
            begin
                ref_cnt <= ref_cnt + 24'h000001;
                // cleared whenever idle and not busy, also when a command starts; a new due wins
                if (state == ST_IDLE && !busy)
                    ref_due <= 1'b0;
            end
        end
    end

    // next-state logic for the strobe sequence
    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (busy)
                    next_state = ST_ROW;
            ST_ROW:
                if (phase_done)
                    // row-only refresh skips the column state; register load does not
                    next_state = (op == `VRC_OP_REF_ROW) ? ST_HOLD
                               : ST_COL;
            ST_COL:
                if (phase_done)
                    next_state = (op == `VRC_OP_LATE_WR) ? ST_LATE
                               : ST_HOLD;
            ST_LATE:
                if (phase_done)
                    next_state = ST_HOLD;
            ST_HOLD:
                if (phase_done)
                    next_state = (op == `VRC_OP_HIDDEN) ? ST_HID
                               : ST_PRE;
            ST_HID:
                if (phase_done)
                    next_state = ST_PRE;
            ST_PRE:
                if (phase_done)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // sequencer, software registers and pin drivers
    always @(posedge sys_clk_i)
    begin
        if (!rst_b_i)
        begin
            state    <= ST_IDLE;
            phase    <= 2'd0;
            op       <= `VRC_OP_READ;
            auto_ref <= 1'b0;
            busy     <= 1'b0;
            cmd      <= `VRC_RST_CMD;
            addr     <= `VRC_RST_ADDR;
            wdata    <= `VRC_RST_DATA;
            rdata    <= 8'h00;
            persist  <= 1'b0;   // device starts nonpersistent; see RULE14
            color_ok <= 1'b0;
            bad_op   <= 1'b0;
            row_strobe_n_o                <= 1'b1;
            column_strobe_n_o             <= 1'b1;
            transfer_or_output_enable_n_o <= 1'b1;
            mask_or_write_enable_n_o      <= 1'b1;
            special_function_select_o     <= 1'b0;
            special_function_select_one_o <= 1'b0;
            multiplexed_address_pins_o    <= 9'h000;
            parallel_data_pins_o          <= 8'h00;
            parallel_data_pins_oe_o       <= 1'b0;
        end
        else
        begin
            // software register writes
            if (wb_hit && wb_we_i && wb_adr_i == `VRC_REG_ADDR)
                addr <= wb_dat_i[17:0];
            if (wb_hit && wb_we_i && wb_adr_i == `VRC_REG_DATA
                && wb_sel_i[0])
                wdata <= wb_dat_i[7:0];
            // status write of bit 3 clears the refused flag
            if (wb_hit && wb_we_i && wb_adr_i == `VRC_REG_STATUS
                && wb_dat_i[`VRC_ST_BAD_OP])
                bad_op <= 1'b0;
            // commands while busy or invalid are refused; set wins
            if (wr_cmd && (busy || !op_ok))
                bad_op <= 1'b1;
            if (wr_cmd)
                cmd[`VRC_CMD_PIN_MSB:`VRC_CMD_REF_EN]
                    <= wb_dat_i[`VRC_CMD_PIN_MSB:`VRC_CMD_REF_EN];
            if (start)
            begin
                cmd[`VRC_CMD_OP_MSB:`VRC_CMD_OP_LSB] <= new_op;
                op       <= new_op;
                busy     <= 1'b1;
                auto_ref <= 1'b0;
            end
            else if (!busy && ref_due && state == ST_IDLE)
            begin
                // timer refresh keeps the masked-write mode
                op       <= `VRC_OP_REF_KEEP;  // see RULE18
                busy     <= 1'b1;
                auto_ref <= 1'b1;
            end

            state <= next_state;
            phase <= (next_state != state) ? 2'd0 : phase + 2'd1;

            case (state)
                ST_IDLE:
                begin
                    // park pins; the device ignores them now, see RULE9
                    row_strobe_n_o                <= 1'b1;
                    column_strobe_n_o             <= 1'b1;
                    transfer_or_output_enable_n_o <= 1'b1;
                    mask_or_write_enable_n_o      <= 1'b1;
                    parallel_data_pins_oe_o       <= 1'b0;
                    if (busy)
                    begin
                        // set up pins one clock before row fall
                        multiplexed_address_pins_o <= addr[17:9];
                        // column low first for refresh; see RULE2
                        column_strobe_n_o <= ~is_cbr;
                        // access needs transfer pin high; see RULE10
                        transfer_or_output_enable_n_o <= 1'b1;
                        // mask enable for masked write
                        mask_or_write_enable_n_o <=
                            ~(op == `VRC_OP_MASK_WR);  // see RULE12
                        // cbr variant coding; see RULE3 RULE17
                        special_function_select_o <= is_load
                            | (is_cbr & op != `VRC_OP_REF_ALL);
                        special_function_select_one_o <=
                            (op == `VRC_OP_REF_STOP);
                        // mask sampled at row fall if nonpersistent
                        parallel_data_pins_o    <= wdata;
                        parallel_data_pins_oe_o <=
                            (op == `VRC_OP_MASK_WR) & ~persist;
                    end
                end
                ST_ROW:
                begin
                    // row address latched on this fall; see RULE4 RULE8
                    row_strobe_n_o <= 1'b0;
                    if (phase_done)
                    begin
                        // column address and column-time selects
                        multiplexed_address_pins_o <= addr[8:0];
                        // block picks column group by 8:2; see RULE21
                        special_function_select_o <=
                            (op == `VRC_OP_BLOCK_WR)      // see RULE20
                            | (op == `VRC_OP_LOAD_COL)    // see RULE24
                            | (op == `VRC_OP_HIDDEN);     // see RULE18
                        // early write: enable low before column fall
                        mask_or_write_enable_n_o <= ~((is_write
                            & op != `VRC_OP_LATE_WR) | is_load);
                        // write data, or column enables on pins 1..4
                        // pin one is column 00; see RULE26 RULE25
                        parallel_data_pins_o <= wdata;
                        parallel_data_pins_oe_o <= (is_write
                            & op != `VRC_OP_LATE_WR) | is_load;
                        // refresh keeps data pins released; see RULE5
                        if (is_cbr || op == `VRC_OP_REF_ROW)
                            parallel_data_pins_oe_o <= 1'b0;
                    end
                end
                ST_COL:
                begin
                    // column latched; early write at this fall; see RULE13
                    column_strobe_n_o <= 1'b0;
                    // read: enable stays high, output enable low
                    if (op == `VRC_OP_READ)
                        transfer_or_output_enable_n_o <= 1'b0;  // RULE11
                    if (phase_done && op == `VRC_OP_LATE_WR)
                    begin
                        parallel_data_pins_o    <= wdata;
                        parallel_data_pins_oe_o <= 1'b1;
                    end
                end
                ST_LATE:
                    // late write: enable falls after column; see RULE13
                    mask_or_write_enable_n_o <= 1'b0;
                ST_HOLD:
                begin
                    // read data from the synchroniser
                    if (phase_done && op == `VRC_OP_READ)
                        rdata <= dq_sync;  // see RULE11
                    if (phase_done && op == `VRC_OP_HIDDEN)
                        row_strobe_n_o <= 1'b1;
                end
                ST_HID:
                begin
                    // column stays low, row toggles; see RULE6
                    row_strobe_n_o          <= ~phase_done;
                    parallel_data_pins_oe_o <= 1'b0;
                end
                ST_PRE:
                begin
                    row_strobe_n_o                <= 1'b1;
                    column_strobe_n_o             <= 1'b1;
                    transfer_or_output_enable_n_o <= 1'b1;
                    mask_or_write_enable_n_o      <= 1'b1;
                    parallel_data_pins_oe_o       <= 1'b0;
                    if (phase_done)
                    begin
                        busy <= 1'b0;
                        // track device mode; see RULE16 RULE17 RULE23
                        if (op == `VRC_OP_LOAD_MASK)
                            persist <= 1'b1;
                        else if (op == `VRC_OP_REF_ALL)
                            persist <= 1'b0;
                        if (op == `VRC_OP_LOAD_COL)
                            color_ok <= 1'b1;
                    end
                end
                default:
                    row_strobe_n_o <= 1'b1;
            endcase
        end
    end

    // one command is one row cycle, so a page shares a mask, see RULE19;
    // every access refreshes its own row as well, see RULE7

endmodule // vrc_ctrl

// file: verification/vrc_ctrl_asserts.sv
// checker on the controller's dram control pins
`timescale 1ns/1ps
module vrc_ctrl_asserts (
    // clock and reset
    input wire       sys_clk_i,
    input wire       rst_b_i,
    // dram pins
    input wire       row_strobe_n_o,
    input wire       column_strobe_n_o,
    input wire       transfer_or_output_enable_n_o,
    input wire       mask_or_write_enable_n_o,
    input wire       special_function_select_o,
    input wire [8:0] multiplexed_address_pins_o,
    input wire       parallel_data_pins_oe_o
);
    wire       row_n = row_strobe_n_o;
    wire       col_n = column_strobe_n_o;
    wire       tr_n  = transfer_or_output_enable_n_o;
    wire       we_n  = mask_or_write_enable_n_o;
    wire       sfs   = special_function_select_o;
    wire       oe    = parallel_data_pins_oe_o;
    wire [8:0] adr   = multiplexed_address_pins_o;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    // access row fall
    sequence row_fall;
        $fell(row_n) && col_n;
    endsequence
    // refresh row fall
    sequence cbr_fall;
        $fell(row_n) && !col_n;
    endsequence
    // column fall in access
    sequence col_fall;
        $fell(col_n) && !row_n;
    endsequence

    cbr_no_drive_a: assert property (!col_n && row_n |-> !oe)
        else $error("data driven before refresh");
    access_tr_a: assert property (row_fall |-> tr_n)
        else $error("transfer pin low at access row fall");
    row_addr_a: assert property (row_fall |-> $stable(adr))
        else $error("address moved at row fall");
    col_addr_a: assert property (col_fall |-> $stable(adr))
        else $error("address moved at column fall");
    read_contend_a: assert property (!row_n && !tr_n |-> !oe)
        else $error("data driven while output enable low");
    mask_sel_a: assert property (row_fall and !we_n |-> !sfs)
        else $error("special select high in masked write");
    cbr_order_a: assert property (cbr_fall |-> !$past(col_n))
        else $error("column not low at refresh");
    block_en_a: assert property (col_fall and sfs |-> oe)
        else $error("block enables not driven");
    early_wr_a: assert property (col_fall and !we_n |-> oe)
        else $error("write data not driven at column fall");
endmodule // vrc_ctrl_asserts

bind vrc_ctrl vrc_ctrl_asserts u_chk (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .row_strobe_n_o(row_strobe_n_o),
    .column_strobe_n_o(column_strobe_n_o),
    .transfer_or_output_enable_n_o(transfer_or_output_enable_n_o),
    .mask_or_write_enable_n_o(mask_or_write_enable_n_o),
    .special_function_select_o(special_function_select_o),
    .multiplexed_address_pins_o(multiplexed_address_pins_o),
    .parallel_data_pins_oe_o(parallel_data_pins_oe_o)
);

// file: verification/vrc_vram_model.sv
// behavioural model of the video dram random port
`timescale 1ns/1ps
module vrc_vram_model (
    // strobes and selects from the controller
    input  wire logic       row_strobe_n_i,
    input  wire logic       column_strobe_n_i,
    input  wire logic       xfer_oe_n_i,
    input  wire logic       mask_we_n_i,
    input  wire logic       sfs_i,
    input  wire logic       sfs_one_i,
    input  wire logic [8:0] addr_i,
    // resolved data bus and the model's own drive
    input  wire logic [7:0] dq_i,
    output logic      [7:0] dq_o,
    output logic            dq_oe_o
);
    logic [7:0] mem [0:262143];    // one byte per row and column
    logic [8:0] row_q, col_q;      // latched addresses
    logic [8:0] ref_ctr  = 9'h000; // internal refresh row
    logic [7:0] mask_q, mask_now, color_q;
    logic       persist  = 1'b0;   // nonpersistent at power-up
    logic       color_ok = 1'b0;
    logic       column_before_row_refresh      = 1'b0;
    logic       masked, load, blk;
    int         n_cbr = 0, n_stop = 0, n_rows = 0, n_bad = 0;

    // cleared array so reads never return unknowns
    initial foreach (mem[i]) mem[i] = 8'h00;

    // row strobe fall decodes the kind of cycle
    always @(negedge row_strobe_n_i)
    begin
        column_before_row_refresh = !column_strobe_n_i;
        if (column_before_row_refresh)
        begin
            ref_ctr = ref_ctr + 9'h001;
            n_cbr++;
            if (!sfs_i) persist = 1'b0;
            else if (sfs_one_i) n_stop++;
        end
        else
        begin
            row_q = addr_i;
            n_rows++;
            if (!xfer_oe_n_i) n_bad++;
            masked = !mask_we_n_i && !sfs_i;
            load = mask_we_n_i && sfs_i;
            mask_now = persist ? mask_q : dq_i;
        end
    end

    // column fall is ignored while the row strobe is high
    always @(negedge column_strobe_n_i)
    begin
        if (!row_strobe_n_i)
        begin
            col_q = addr_i;
            blk = sfs_i;
            if (!mask_we_n_i) store();
        end
    end

    // late write: enable falls after column
    always @(negedge mask_we_n_i)
        if (!row_strobe_n_i && !column_strobe_n_i && !column_before_row_refresh) store();

    // data taken at the later strobe
    task automatic store();
        logic [7:0]  m;
        logic [17:0] a;
        m = masked ? mask_now : 8'hff;
        if (load)
        begin
            if (blk) color_q = dq_i;
            else mask_q = dq_i;
            if (blk) color_ok = 1'b1;
            else persist = 1'b1;
        end
        else if (blk)
        begin
            if (!color_ok) n_bad++;
            for (int k = 0; k < 4; k++)
            begin
                a = {row_q, col_q[8:2], k[1:0]};
                if (dq_i[k]) mem[a] = (mem[a] & ~m) | (color_q & m);
            end
        end
        else
            mem[{row_q, col_q}] = (mem[{row_q, col_q}] & ~m) | (dq_i & m);
    endtask

    // read data only while output enable is low
    assign dq_oe_o = !row_strobe_n_i && !column_strobe_n_i && !xfer_oe_n_i
                     && mask_we_n_i && !column_before_row_refresh;
    assign dq_o = mem[{row_q, col_q}];
endmodule // vrc_vram_model

// file: verification/vrc_ctrl_tb.sv
// self-checking bench for the random port cycle controller
`timescale 1ns/1ps
`include "vrc_map.vh"
module vrc_ctrl_tb;
    localparam int REF_IV = 40;  // short spacing, brief run
    logic        sys_clk_i, rst_b_i, cyc, stb, we;
    logic [3:0]  adr;
    logic [31:0] dat, rdat;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, row_n, col_n, tr_n, we_n, sfs, sfs1, d_oe, m_oe;
    wire  [8:0]  maddr;
    wire  [7:0]  d_q, m_q, dq_bus;
    logic [7:0]  dq_last = 8'h00;
    int          n_mismatch = 0, checks_done = 0;

    vrc_ctrl #(.REF_INTERVAL(REF_IV)) i_dut (
        .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .row_strobe_n_o(row_n),
        .column_strobe_n_o(col_n), .transfer_or_output_enable_n_o(tr_n),
        .mask_or_write_enable_n_o(we_n), .special_function_select_o(sfs),
        .special_function_select_one_o(sfs1),
        .multiplexed_address_pins_o(maddr), .parallel_data_pins_i(dq_bus),
        .parallel_data_pins_o(d_q), .parallel_data_pins_oe_o(d_oe));

    vrc_vram_model i_vram (
        .row_strobe_n_i(row_n), .column_strobe_n_i(col_n),
        .xfer_oe_n_i(tr_n), .mask_we_n_i(we_n), .sfs_i(sfs),
        .sfs_one_i(sfs1), .addr_i(maddr), .dq_i(dq_bus), .dq_o(m_q),
        .dq_oe_o(m_oe));

    // released bus shows the inverse of its last value
    assign dq_bus = d_oe ? d_q : (m_oe ? m_q : ~dq_last);
    always @(posedge sys_clk_i) dq_last <= dq_bus;

    initial
    begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    // classic wishbone cycle, held to ack
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        @(posedge sys_clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do
            @(posedge sys_clk_i);
        while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
            n_mismatch++;
        end
    endtask

    // one dram cycle, then poll busy
    task automatic op(input logic [7:0] c, input logic [17:0] a,
                      input logic [7:0] d);
        wb(1'b1, `VRC_REG_ADDR, {14'h0, a});
        wb(1'b1, `VRC_REG_DATA, {24'h0, d});
        wb(1'b1, `VRC_REG_CMD, {24'h0, c});
        do
            wb(1'b0, `VRC_REG_STATUS, 32'h0);
        while (rdat[`VRC_ST_BUSY] !== 1'b0);
    endtask

    task automatic st(input logic [3:0] exp);
        chk(rdat, {28'h0, exp});
    endtask

    task automatic t_reset();
        wb(1'b0, `VRC_REG_STATUS, 32'h0);
        st(4'h0);
        wb(1'b0, `VRC_REG_CMD, 32'h0);
        chk(rdat, {24'h0, `VRC_RST_CMD});
        wb(1'b0, 4'h2, 32'h0);  // unmapped offset must still answer
    endtask

    task automatic t_access();
        op(`VRC_OP_WRITE, 18'h2a5c3, 8'h5a);
        chk(i_vram.mem[18'h2a5c3], 8'h5a);
        op(`VRC_OP_LATE_WR, 18'h3fffe, 8'hc3);
        chk(i_vram.mem[18'h3fffe], 8'hc3);
        op(`VRC_OP_READ, 18'h2a5c3, 8'h00);
        wb(1'b0, `VRC_REG_DATA, 32'h0);
        chk({24'h0, rdat[15:8]}, 32'h5a);
        chk(i_vram.n_rows, 3);
    endtask

    task automatic t_mask();
        op(`VRC_OP_WRITE, 18'h00100, 8'hf0);
        op(`VRC_OP_MASK_WR, 18'h00100, 8'h0f);
        chk(i_vram.mem[18'h00100], 8'hff);
        op(`VRC_OP_LOAD_MASK, 18'h0, 8'h81);
        st(4'h2);
        op(`VRC_OP_MASK_WR, 18'h00101, 8'h7e);
        chk(i_vram.mem[18'h00101], 8'h00);
        op(`VRC_OP_REF_KEEP, 18'h0, 8'h00);
        chk(i_vram.persist, 1);
        op(`VRC_OP_REF_STOP, 18'h0, 8'h00);
        chk(i_vram.n_stop, 1);
        op(`VRC_OP_REF_ALL, 18'h0, 8'h00);
        chk(i_vram.persist, 0);
        chk(i_vram.ref_ctr, 3);
    endtask

    task automatic t_block();
        op(`VRC_OP_BLOCK_WR, 18'h15505, 8'h05);
        st(4'h8);
        wb(1'b1, `VRC_REG_STATUS, 32'h8);
        op(8'h0c, 18'h0, 8'h00);
        st(4'h8);
        wb(1'b1, `VRC_REG_STATUS, 32'h8);
        op(`VRC_OP_LOAD_COL, 18'h0, 8'ha5);
        st(4'h4);
        op(`VRC_OP_BLOCK_WR, 18'h15505, 8'h05);
        chk(i_vram.mem[18'h15504], 8'ha5);
        chk(i_vram.mem[18'h15505], 8'h00);
        chk(i_vram.mem[18'h15506], 8'ha5);
        chk(i_vram.mem[18'h15507], 8'h00);
        chk(i_vram.n_bad, 0);
    endtask

    task automatic t_refresh();
        int c0;
        op(`VRC_OP_REF_ROW, 18'h1ff00, 8'h00);
        chk(i_vram.row_q, 9'h0ff);
        c0 = i_vram.n_cbr;
        op(`VRC_OP_HIDDEN, 18'h0, 8'h00);
        chk(i_vram.n_cbr - c0, 2);
        c0 = i_vram.n_cbr;
        op(8'h10 | `VRC_OP_REF_ROW, 18'h0, 8'h00);
        repeat (REF_IV * 6) @(posedge sys_clk_i);
        chk(i_vram.n_cbr - c0 >= 4, 1);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial
    begin
        rst_b_i = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        dat = 32'h0;
        repeat (8) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_access();
        t_mask();
        t_block();
        t_refresh();
        print_verdict();
    end

    // watchdog
    initial
    begin
        repeat (40000) @(posedge sys_clk_i);
        n_mismatch++;
        print_verdict();
    end
endmodule // vrc_ctrl_tb
